// [inc/mres_pkg.sv]
// Purpose: Shared constants and types of the memory replay event selector.
// Assumes: AXI4-Lite register bus with 32-bit data and 8-bit addresses.
// Notes:   Every register offset, register field position, event code and register reset value lives here.
package mres_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses.
   localparam logic [7:0]  SEL_BASE = 8'h00;   // Eight selection registers.
   localparam logic [7:0]  CFG_BASE = 8'h20;   // Eight configuration regs.
   localparam logic [7:0]  CNT_BASE = 8'h40;   // Eight counters.
   localparam logic [7:0]  MAP_END  = 8'h60;   // First unmapped address.
   localparam int          NUM_SLOT = 8;       // Counters 0-3 and 8-11.

   // Order of the selection registers inside the selection block.
   localparam logic [2:0]  SEL_SPLIT_A = 3'h0; // split_access_select_reg_a.
   localparam logic [2:0]  SEL_SPLIT_B = 3'h1; // split_access_select_reg_b.
   localparam logic [2:0]  SEL_ORD_A   = 3'h2; // ordering_select_reg_a.
   localparam logic [2:0]  SEL_ORD_B   = 3'h3; // ordering_select_reg_b.
   localparam logic [2:0]  SEL_WALK_A  = 3'h4; // walk_select_reg_a.
   localparam logic [2:0]  SEL_WALK_B  = 3'h5; // walk_select_reg_b.
   localparam logic [2:0]  SEL_CACHE_A = 3'h6; // bus_cache_select_reg_a.
   localparam logic [2:0]  SEL_CACHE_B = 3'h7; // bus_cache_select_reg_b.

   ////////////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int CODE_HI = 31;                // Event code, upper bit.
   localparam int CODE_LO = 25;                // Event code, lower bit.
   localparam int MASK_HI = 24;                // Cause mask, upper bit.
   localparam int MASK_LO = 9;                 // Cause mask, lower bit.
   localparam int CSEL_HI = 15;                // Configuration select, upper.
   localparam int CSEL_LO = 13;                // Configuration select, lower.
   localparam int CNT_EN  = 12;                // Counter enable bit.

   // Event codes and configuration-select codes.
   localparam logic [6:0] CODE_SPLIT_RD = 7'h04;  // Load path retry.
   localparam logic [6:0] CODE_SPLIT_WR = 7'h05;  // Store path retry.
   localparam logic [6:0] CODE_REORDER  = 7'h03;  // Load reorder replay.
   localparam logic [6:0] CODE_WALK     = 7'h01;  // Table walk kind.
   localparam logic [6:0] CODE_CACHE    = 7'h0C;  // Bus queue cache lookup.
   localparam logic [2:0] CSEL_RETRY    = 3'h2;   // Retry and reorder events.
   localparam logic [2:0] CSEL_WALK     = 3'h4;   // Table walk kind.
   localparam logic [2:0] CSEL_CACHE    = 3'h7;   // Bus queue cache lookup.

   // Cause positions inside the mask field.
   localparam int BIT_SPLIT    = 1;            // Split read or split write.
   localparam int BIT_NO_ADDR  = 1;            // Unknown store address.
   localparam int BIT_NO_VALUE = 3;            // Unknown store value.
   localparam int BIT_PARTIAL  = 4;            // Partial byte overlap.
   localparam int BIT_LOW_ADDR = 5;            // Low address mismatch.
   localparam int BIT_DWALK    = 0;            // Data walk.
   localparam int BIT_IWALK    = 1;            // Instruction walk.
   localparam logic [10:0] CACHE_BITS = 11'h73F; // Defined cache mask bits.

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and bus answers.
   localparam logic [31:0] REG_RST     = 32'h00000000; // All registers.
   localparam logic [1:0]  RESP_OKAY   = 2'h0;         // Normal answer.
   localparam logic [1:0]  RESP_SLVERR = 2'h2;         // Unmapped address.

   // Event sources from the memory pipeline, one-cycle pulses or levels.
   typedef struct packed {
      logic        split_read_cause;             // Load split replay.
      logic        split_write_cause;            // Store split replay.
      logic        unknown_store_address_cause;  // Older store, no address.
      logic        unknown_store_value_cause;    // Older store, no value.
      logic        partial_overlap_cause;        // Bytes partly overlap.
      logic        low_address_mismatch_cause;   // Low 4 address bits differ.
      logic        data_walk_cause;              // Data translation miss walk.
      logic        instruction_walk_cause;       // Instruction miss walk.
      logic [10:0] bus_cache_lookup;             // Per cache mask bit.
   } mres_cause_s;

   // Merge write data into a register under the byte strobes.
   function automatic logic [31:0] mres_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

endpackage

// [hdl/mres_counter.sv]
// Purpose: One qualified event counter with its event matching.
// Assumes: Cause inputs are synchronous to aclk.
// Notes:   SPLIT_GROUP selects counters 8-11 rather than counters 0-3.
`timescale 1ns/10ps

module mres_counter
   import mres_pkg::*;
#(
   parameter bit SPLIT_GROUP = 1'b0           // Split-access counter group.
) (
   input  wire logic        aclk,              // Core clock.
   input  wire logic        aresetn,           // Synchronous reset, low.
   input  wire logic [31:0] sel_split,         // Split-access selection.
   input  wire logic [31:0] sel_ord,           // Ordering selection.
   input  wire logic [31:0] sel_walk,          // Walk selection.
   input  wire logic [31:0] sel_cache,         // Bus cache selection.
   input  wire logic [31:0] cfg,               // Counter configuration.
   input  wire mres_cause_s causes,            // Event sources.
   input  wire logic        wr_en,             // Software load of the count.
   input  wire logic [31:0] wr_data,           // Value to load.
   output logic      [31:0] count              // Current count.
);

   logic [31:0] count_r;
   logic [31:0] count_nxt;
   logic        hit;
   logic [2:0]  csel;
   logic [15:0] reorder_vec;
   logic [15:0] walk_vec;
   logic [15:0] cache_vec;

   assign csel = cfg[CSEL_HI:CSEL_LO];

   // Cause vectors laid out on the mask bit positions.
   always_comb begin
      reorder_vec = 16'h0000;
      walk_vec    = 16'h0000;
      cache_vec   = 16'h0000;
      reorder_vec[BIT_NO_ADDR]  = causes.unknown_store_address_cause;
      reorder_vec[BIT_NO_VALUE] = causes.unknown_store_value_cause;
      reorder_vec[BIT_PARTIAL]  = causes.partial_overlap_cause;
      reorder_vec[BIT_LOW_ADDR] = causes.low_address_mismatch_cause;
      walk_vec[BIT_DWALK]       = causes.data_walk_cause;
      walk_vec[BIT_IWALK]       = causes.instruction_walk_cause;
      cache_vec[10:0]           = causes.bus_cache_lookup & CACHE_BITS;
   end

   // Event match: code, configuration select and any selected cause.
   always_comb begin
      hit = 1'b0;
      if (SPLIT_GROUP) begin
         if (csel == CSEL_RETRY &&
             sel_split[CODE_HI:CODE_LO] == CODE_SPLIT_RD) begin
            hit = sel_split[MASK_LO + BIT_SPLIT] & causes.split_read_cause;
         end
         if (csel == CSEL_RETRY &&
             sel_split[CODE_HI:CODE_LO] == CODE_SPLIT_WR) begin
            hit = sel_split[MASK_LO + BIT_SPLIT] &
                  causes.split_write_cause;
         end
      end else begin
         if (csel == CSEL_RETRY &&
             sel_ord[CODE_HI:CODE_LO] == CODE_REORDER) begin
            hit = |(sel_ord[MASK_HI:MASK_LO] &
                    reorder_vec);
         end
         if (csel == CSEL_WALK &&
             sel_walk[CODE_HI:CODE_LO] == CODE_WALK) begin
            hit = |(sel_walk[MASK_HI:MASK_LO] & walk_vec);
         end
         if (csel == CSEL_CACHE &&
             sel_cache[CODE_HI:CODE_LO] == CODE_CACHE) begin
            hit = |(sel_cache[MASK_HI:MASK_LO] & cache_vec);
         end
      end
   end

   // Next count: a software load wins over an event in the same cycle.
   always_comb begin
      count_nxt = count_r;
      if (wr_en) begin
         count_nxt = wr_data;
      end else if (cfg[CNT_EN] && hit) begin
         count_nxt = count_r + 32'h00000001;
      end
   end

   // Count register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_r <= REG_RST;
      end else begin
         count_r <= count_nxt;
      end
   end

   assign count = count_r;

endmodule

// [hdl/mres_top.sv]
// Purpose: Memory replay event selector with counters behind AXI4-Lite.
// Assumes: One clock, synchronous active-low reset, synchronous event inputs.
// Notes:   Selection, configuration and count registers are word aligned.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Store path retry counts with code 05H, config select 02H, mask bit 1.
// - Load reorder replay uses code 03H with config select 02H.
// - Reorder mask bit 1 selects replays for an unknown store address.
// - Reorder mask bit 3 selects replays for an unknown store value.
// - Reorder mask bit 4 selects replays for partly overlapping bytes.
// - Reorder mask bit 5 selects replays for low address bit mismatch.
// - Table walk kind uses code 01H with config select 04H.
// - Walk mask bit 0 selects walks caused by a data translation miss.
// - Walk mask bit 1 selects walks caused by an instruction miss.
// - Bus cache lookups count by selected access type and result.
// - Reads cover loads and ownership reads, writes cover writebacks.
// - An event counts when any one of the selected causes applies.
// - Split events feed counters 8 to 11, the others counters 0 to 3.
// - Cache mask bits 0-5 are hits by level and state, 8-10 misses.
module mres_top
   import mres_pkg::*;
(
   input  wire logic        aclk,              // Core clock, 10 MHz.
   input  wire logic        aresetn,           // Synchronous reset, low.
   input  wire logic [7:0]  s_axi_awaddr,      // Write address.
   input  wire logic        s_axi_awvalid,     // Write address valid.
   output logic             s_axi_awready,     // Write address ready.
   input  wire logic [31:0] s_axi_wdata,       // Write data.
   input  wire logic [3:0]  s_axi_wstrb,       // Write byte strobes.
   input  wire logic        s_axi_wvalid,      // Write data valid.
   output logic             s_axi_wready,      // Write data ready.
   output logic      [1:0]  s_axi_bresp,       // Write response.
   output logic             s_axi_bvalid,      // Write response valid.
   input  wire logic        s_axi_bready,      // Write response ready.
   input  wire logic [7:0]  s_axi_araddr,      // Read address.
   input  wire logic        s_axi_arvalid,     // Read address valid.
   output logic             s_axi_arready,     // Read address ready.
   output logic      [31:0] s_axi_rdata,       // Read data.
   output logic      [1:0]  s_axi_rresp,       // Read response.
   output logic             s_axi_rvalid,      // Read data valid.
   input  wire logic        s_axi_rready,      // Read data ready.
   input  wire mres_cause_s causes             // Memory pipeline events.
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic        awready_r;
   logic        awready_nxt;
   logic        wready_r;
   logic        wready_nxt;
   logic        bvalid_r;
   logic        bvalid_nxt;
   logic [1:0]  bresp_r;
   logic [1:0]  bresp_nxt;
   logic        aw_held_r;
   logic        aw_held_nxt;
   logic        w_held_r;
   logic        w_held_nxt;
   logic [7:0]  awaddr_r;
   logic [7:0]  awaddr_nxt;
   logic [31:0] wdata_r;
   logic [31:0] wdata_nxt;
   logic [3:0]  wstrb_r;
   logic [3:0]  wstrb_nxt;
   logic        arready_r;
   logic        arready_nxt;
   logic        rvalid_r;
   logic        rvalid_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [1:0]  rresp_r;
   logic [1:0]  rresp_nxt;

   logic [31:0] sel_r   [NUM_SLOT];
   logic [31:0] sel_nxt [NUM_SLOT];
   logic [31:0] cfg_r   [NUM_SLOT];
   logic [31:0] cfg_nxt [NUM_SLOT];
   logic [31:0] cnt_val [NUM_SLOT];
   logic [NUM_SLOT-1:0] cnt_wr;

   logic        aw_take;
   logic        w_take;
   logic        ar_take;
   logic        do_write;
   logic        wr_mapped;
   logic [1:0]  wr_region;
   logic [2:0]  wr_slot;
   logic [31:0] wr_word;
   logic [1:0]  rd_region;
   logic [2:0]  rd_slot;

   ////////////////////////////////////////////////////////////////////////////
   // Handshake terms and address decode.
   assign aw_take   = s_axi_awvalid & awready_r;
   assign w_take    = s_axi_wvalid & wready_r;
   assign ar_take   = s_axi_arvalid & arready_r;
   assign do_write  = aw_held_r & w_held_r & ~bvalid_r;
   assign wr_mapped = (awaddr_r < MAP_END);
   assign wr_region = awaddr_r[6:5];
   assign wr_slot   = awaddr_r[4:2];
   assign rd_region = s_axi_araddr[6:5];
   assign rd_slot   = s_axi_araddr[4:2];

   // Write channel: address and data are taken in either order.
   always_comb begin
      aw_held_nxt = aw_held_r;
      w_held_nxt  = w_held_r;
      awaddr_nxt  = awaddr_r;
      wdata_nxt   = wdata_r;
      wstrb_nxt   = wstrb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      if (aw_take) begin
         aw_held_nxt = 1'b1;
         awaddr_nxt  = s_axi_awaddr;
      end
      if (w_take) begin
         w_held_nxt = 1'b1;
         wdata_nxt  = s_axi_wdata;
         wstrb_nxt  = s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (do_write) begin
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      awready_nxt = ~aw_held_nxt & ~bvalid_nxt;
      wready_nxt  = ~w_held_nxt & ~bvalid_nxt;
   end

   // Write channel registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awaddr_r  <= 8'h00;
         wdata_r   <= REG_RST;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
      end else begin
         aw_held_r <= aw_held_nxt;
         w_held_r  <= w_held_nxt;
         awaddr_r  <= awaddr_nxt;
         wdata_r   <= wdata_nxt;
         wstrb_r   <= wstrb_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Selection and configuration registers, written under byte strobes.
   always_comb begin
      wr_word = REG_RST;
      cnt_wr  = '0;
      for (int i = 0; i < NUM_SLOT; i++) begin
         sel_nxt[i] = sel_r[i];
         cfg_nxt[i] = cfg_r[i];
      end
      if (do_write && wr_mapped) begin
         case (wr_region)
            2'h0: begin
               sel_nxt[wr_slot] = mres_merge(sel_r[wr_slot], wdata_r,
                                             wstrb_r);
            end
            2'h1: begin
               cfg_nxt[wr_slot] = mres_merge(cfg_r[wr_slot], wdata_r,
                                             wstrb_r);
            end
            2'h2: begin
               wr_word         = mres_merge(cnt_val[wr_slot], wdata_r,
                                            wstrb_r);
               cnt_wr[wr_slot] = 1'b1;
            end
            default: begin
               wr_word = REG_RST;
            end
         endcase
      end
   end

   // Register file storage.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_SLOT; i++) begin
            sel_r[i] <= REG_RST;
            cfg_r[i] <= REG_RST;
         end
      end else begin
         for (int i = 0; i < NUM_SLOT; i++) begin
            sel_r[i] <= sel_nxt[i];
            cfg_r[i] <= cfg_nxt[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel: data registered one cycle after the address is taken.
   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt  = rdata_r;
      rresp_nxt  = rresp_r;
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (ar_take) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = RESP_OKAY;
         if (s_axi_araddr >= MAP_END) begin
            rdata_nxt = REG_RST;
            rresp_nxt = RESP_SLVERR;
         end else begin
            case (rd_region)
               2'h0:    rdata_nxt = sel_r[rd_slot];
               2'h1:    rdata_nxt = cfg_r[rd_slot];
               2'h2:    rdata_nxt = cnt_val[rd_slot];
               default: rdata_nxt = REG_RST;
            endcase
         end
      end
      arready_nxt = ~rvalid_nxt;
   end

   // Read channel registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r  <= 1'b0;
         rdata_r   <= REG_RST;
         rresp_r   <= RESP_OKAY;
         arready_r <= 1'b0;
      end else begin
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
         arready_r <= arready_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counters: slots 0-3 are counters 0-3, slots 4-7 are counters 8-11.
   // Counters 0,1 and 8,9 read the first register of a pair, the rest
   // the second, so an event can only land on its own counters.
   for (genvar k = 0; k < NUM_SLOT; k++) begin : g_cnt
      localparam bit USE_B = (k % 4) >= 2;
      mres_counter #(
         .SPLIT_GROUP (k >= 4)
      ) u_cnt (
         .aclk      (aclk),
         .aresetn   (aresetn),
         .sel_split (USE_B ? sel_r[SEL_SPLIT_B] : sel_r[SEL_SPLIT_A]),
         .sel_ord   (USE_B ? sel_r[SEL_ORD_B]   : sel_r[SEL_ORD_A]),
         .sel_walk  (USE_B ? sel_r[SEL_WALK_B]  : sel_r[SEL_WALK_A]),
         .sel_cache (USE_B ? sel_r[SEL_CACHE_B] : sel_r[SEL_CACHE_A]),
         .cfg       (cfg_r[k]),
         .causes    (causes),
         .wr_en     (cnt_wr[k]),
         .wr_data   (wr_word),
         .count     (cnt_val[k])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus outputs, all from flip-flops.
   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

endmodule

// [testbench/mres_checker.sv]
// Purpose: Bus timing assertions at the ports of the event selector.
// Assumes: Single clock domain, synchronous active-low reset.
// Notes:   Bound to every mres_top instance by the bind at the foot.
`timescale 1ns/10ps

module mres_checker
   import mres_pkg::*;
(
   input wire logic        aclk,           // Core clock.
   input wire logic        aresetn,        // Reset, low.
   input wire logic [7:0]  s_axi_awaddr,   // Write address.
   input wire logic        s_axi_awvalid,  // Write address valid.
   input wire logic        s_axi_awready,  // Write address ready.
   input wire logic        s_axi_wvalid,   // Write data valid.
   input wire logic        s_axi_wready,   // Write data ready.
   input wire logic [1:0]  s_axi_bresp,    // Write response.
   input wire logic        s_axi_bvalid,   // Response valid.
   input wire logic        s_axi_bready,   // Response ready.
   input wire logic [7:0]  s_axi_araddr,   // Read address.
   input wire logic        s_axi_arvalid,  // Read address valid.
   input wire logic        s_axi_arready,  // Read address ready.
   input wire logic [31:0] s_axi_rdata,    // Read data.
   input wire logic [1:0]  s_axi_rresp,    // Read response.
   input wire logic        s_axi_rvalid,   // Read data valid.
   input wire logic        s_axi_rready    // Read data ready.
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////////////////////
   // A joint take answers two edges later, code chosen by the address.
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready && s_axi_awaddr < MAP_END
      |-> ##2 s_axi_bvalid && s_axi_bresp == RESP_OKAY)
      else $error("write answer late or not okay");
   a_write_refused: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready && s_axi_awaddr >= MAP_END
      |-> ##2 s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_write_busy: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while answer pending");
   a_write_ready: assert property (s_axi_bvalid && s_axi_bready
      |-> ##[1:2] s_axi_awready && s_axi_wready)
      else $error("write ready not restored");
   // A read answers one edge after the take and holds until taken.
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr >= MAP_END
      |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 0)
      else $error("unmapped read not refused");
   a_read_latency: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped early");
   a_read_ready: assert property (s_axi_rvalid && s_axi_rready
      |-> ##[1:2] s_axi_arready)
      else $error("read ready not restored");
endmodule

bind mres_top mres_checker u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for the memory replay event selector.
// Assumes: Bus tasks are entered just after a rising clock edge.
// Notes:   Each trial programs one counter, fires causes, reads the count.
`timescale 1ns/10ps

module tb_top
   import mres_pkg::*;
;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   mres_cause_s causes;
   int bad_count, check_count;
   int rm[4] = '{1, 3, 4, 5};
   int rc[4] = '{16, 15, 14, 13};
   int cb[9] = '{0, 1, 2, 3, 4, 5, 8, 9, 10};

   mres_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .causes(causes));

   ////////////////////////////////////////////////////////////////////////////
   // Clock of 100 ns period.
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   // Compares, counts and reports one value.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One write with both channels offered together.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      bit ad, dd;
      ad = 0;
      dd = 0;
      awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (!ad && awready) begin ad = 1; awvalid <= 0; end
         if (!dd && wready) begin dd = 1; wvalid <= 0; end
      end
      bready <= 1;
      do @(posedge aclk); while (!bvalid);
      chk({30'h0, bresp}, {30'h0, er});
      bready <= 0;
   endtask

   // One read, rready raised once the address is taken.
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      araddr <= a; arvalid <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0; rready <= 1;
      do @(posedge aclk); while (!rvalid);
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, er});
      rready <= 0;
   endtask

   // Program a selection and a counter, fire causes for n cycles, read.
   task automatic trial(input logic [7:0] so, input logic [6:0] code,
      input logic [15:0] m, input logic [2:0] sl, input logic [2:0] cs,
      input logic [18:0] cv, input int n, input logic [31:0] e);
      wr(so, {code, m, 9'h000}, 4'hF, RESP_OKAY);
      wr(CFG_BASE + {3'h0, sl, 2'h0}, {16'h0, cs, 13'h1000}, 4'hF, 2'h0);
      wr(CNT_BASE + {3'h0, sl, 2'h0}, 32'h0, 4'hF, RESP_OKAY);
      causes <= mres_cause_s'(cv);
      repeat (n) @(posedge aclk);
      causes <= '0;
      repeat (2) @(posedge aclk);
      rd(CNT_BASE + {3'h0, sl, 2'h0}, e, RESP_OKAY);
   endtask

   task automatic results();
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog against a hung handshake.
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      results();
   end

   // Main sequence.
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb, causes} = '0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 24; i++) rd(8'(4 * i), REG_RST, RESP_OKAY);
      rd(MAP_END, 32'h0, RESP_SLVERR);
      wr(8'hFC, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
      wr(8'h5C, 32'hAABBCCDD, 4'h2, RESP_OKAY);
      rd(8'h5C, 32'h0000CC00, RESP_OKAY);
      for (int i = 0; i < 4; i++)
         for (int j = 0; j < 4; j++)
            trial(8'h08, CODE_REORDER, 16'(1 << rm[i]), 3'd0, CSEL_RETRY,
               19'(1 << rc[j]), 1, {31'h0, i == j});
      trial(8'h0C, CODE_REORDER, 16'h3A, 3'd3, 3'h2, 19'h1E000, 1, 1);
      trial(8'h0C, CODE_REORDER, 16'h3A, 3'd3, 3'h2, 19'h04000, 5, 5);
      trial(8'h08, CODE_REORDER, 16'h3A, 3'd1, 3'h4, 19'h1E000, 1, 0);
      trial(8'h08, 7'h02, 16'h3A, 3'd0, 3'h2, 19'h1E000, 1, 0);
      for (int i = 0; i < 2; i++)
         for (int j = 0; j < 2; j++)
            trial(8'h14, CODE_WALK, 16'(1 << i), 3'd2, CSEL_WALK,
               19'(1 << (12 - j)), 1, {31'h0, i == j});
      for (int i = 0; i < 9; i++) begin
         trial(8'h18, CODE_CACHE, 16'(1 << cb[i]), 3'd1, CSEL_CACHE,
            19'(1 << cb[i]), 1, 1);
         trial(8'h18, CODE_CACHE, 16'(1 << cb[i]), 3'd1, CSEL_CACHE,
            19'h7FF ^ 19'(1 << cb[i]), 1, 0);
      end
      trial(8'h18, CODE_CACHE, 16'hC0, 3'd1, CSEL_CACHE, 19'hC0, 1, 0);
      trial(8'h04, CODE_SPLIT_RD, 16'h2, 3'd7, 3'h2, 19'h40000, 1, 1);
      trial(8'h04, CODE_SPLIT_RD, 16'h2, 3'd7, 3'h2, 19'h20000, 1, 0);
      trial(8'h04, CODE_SPLIT_WR, 16'h2, 3'd6, 3'h2, 19'h20000, 1, 1);
      trial(8'h04, CODE_SPLIT_WR, 16'h2, 3'd6, 3'h2, 19'h40000, 1, 0);
      trial(8'h08, CODE_REORDER, 16'h3A, 3'd5, 3'h2, 19'h1E000, 1, 0);
      trial(8'h00, CODE_SPLIT_RD, 16'h2, 3'd0, 3'h2, 19'h40000, 1, 0);
      results();
   end
endmodule
